/* File: common/toc_defines.vh */
`ifndef TOC_DEFINES_VH
`define TOC_DEFINES_VH
// Register byte offsets
`define TOC_CTRL_OFS 12'h000
`define TOC_COUNT_OFS 12'h004
`define TOC_CMP_A_OFS 12'h008
`define TOC_CMP_B_OFS 12'h00c
`define TOC_CMP_C_OFS 12'h010
`define TOC_FLAGS_OFS 12'h014
`define TOC_IRQEN_OFS 12'h018
`define TOC_FORCE_OFS 12'h01c
`define TOC_CAPTURE_OFS 12'h020
`define TOC_STATE_OFS 12'h024
`define TOC_TEMP_OFS 12'h028
`define TOC_CMP_LOW_OFS 12'h02c
// CTRL fields
`define TOC_CTRL_WGM_LSB 0
`define TOC_CTRL_COMA_LSB 4
`define TOC_CTRL_COMB_LSB 6
`define TOC_CTRL_COMC_LSB 8
`define TOC_CTRL_RUN_BIT 10
`define TOC_CTRL_DIR_LSB 12
`define TOC_CTRL_PORT_LSB 16
// Waveform selections
`define TOC_WGM_NORMAL 4'h0
`define TOC_WGM_CTC_A 4'h4
`define TOC_WGM_CTC_CAP 4'hc
`define TOC_WGM_FAST_A 4'hf
`define TOC_WGM_PCORR_A 4'hb
`define TOC_WGM_PFCORR_A 4'h9
// Reset values and counter limits
`define TOC_CTRL_RST 32'h0000_0000
`define TOC_CMP_RST 16'h0000
`define TOC_MAX 16'hffff
`define TOC_BOTTOM 16'h0000
`endif

/* File: hw/toc_timer16_output_compare.v */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "toc_defines.vh"
module toc_timer16_output_compare (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Timer
    input wire timer_tick,
    input wire capture_event,
    input wire [2:0] irq_ack,
    output reg [2:0] compare_irq,
    // Pins
    output reg [2:0] pin_out,
    output reg [2:0] output_pin_direction
);

    reg [31:0] ctrl;
    reg [15:0] timer_count;
    reg count_up;
    wire [15:0] active_a, active_b, active_c;
    wire [15:0] buf_a, buf_b, buf_c;
    reg [7:0] temp_high;
    reg [2:0] compare_match_flag;
    reg [2:0] compare_irq_enable;
    reg capture_flag;
    reg [15:0] capture_value;
    reg [2:0] compare_output_state;
    reg [2:0] match_d;
    reg block_pending;
    reg [2:0] flag_clear;
    reg [2:0] next_match_flag;

    wire [3:0] waveform_gen_select = ctrl[`TOC_CTRL_WGM_LSB +: 4];
    wire [1:0] com_a = ctrl[`TOC_CTRL_COMA_LSB +: 2];
    wire [1:0] com_b = ctrl[`TOC_CTRL_COMB_LSB +: 2];
    wire [1:0] com_c = ctrl[`TOC_CTRL_COMC_LSB +: 2];
    wire run = ctrl[`TOC_CTRL_RUN_BIT];
    wire [2:0] port_val = ctrl[`TOC_CTRL_PORT_LSB +: 3];

    wire non_pwm = (waveform_gen_select == `TOC_WGM_NORMAL) ||
        (waveform_gen_select == `TOC_WGM_CTC_A) ||
        (waveform_gen_select == `TOC_WGM_CTC_CAP);
    wire top_a = (waveform_gen_select == `TOC_WGM_CTC_A) ||
        (waveform_gen_select == `TOC_WGM_FAST_A) ||
        (waveform_gen_select == `TOC_WGM_PCORR_A) ||
        (waveform_gen_select == `TOC_WGM_PFCORR_A);
    wire dual_slope = (waveform_gen_select == `TOC_WGM_PCORR_A) ||
        (waveform_gen_select == `TOC_WGM_PFCORR_A);
    wire [15:0] top_val = top_a ? active_a : `TOC_MAX;

    wire wr = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire wr_count = wr && (paddr == `TOC_COUNT_OFS);
    wire wr_force = wr && (paddr == `TOC_FORCE_OFS);
    wire wr_flags = wr && (paddr == `TOC_FLAGS_OFS);
    wire wr_low = wr && (paddr == `TOC_CMP_LOW_OFS);
    wire [15:0] low_word = {temp_high, pwdata[7:0]};
    // Low byte write also names the channel
    wire wr_low_a = wr_low && (pwdata[9:8] == 2'h0);
    wire wr_low_b = wr_low && (pwdata[9:8] == 2'h1);
    wire wr_low_c = wr_low && (pwdata[9:8] == 2'h2);

    // Full 16-bit equality per channel
    wire [2:0] match_raw = {timer_count == active_c, timer_count == active_b,
        timer_count == active_a};
    // Matches on the tick after a count write are suppressed
    wire [2:0] match = (timer_tick && !block_pending) ? match_raw : 3'h0;
    wire at_top = timer_tick && (timer_count == top_val);
    wire at_bottom = timer_tick && (timer_count == `TOC_BOTTOM);
    // Phase and frequency correct loads at BOTTOM, so both slopes match
    wire pf_correct = (waveform_gen_select == `TOC_WGM_PFCORR_A);
    wire reload = pf_correct ? at_bottom : (at_top && !non_pwm);

    wire [2:0] force_hit = (wr_force && non_pwm) ? pwdata[2:0] : 3'h0;
    wire [2:0] act = match | force_hit;

    // Buffer and active word per channel
    toc_compare_slot #(
        .WIDTH(16)
    ) i_toc_compare_slot_a (
        .pclk(pclk),
        .presetn(presetn),
        .write_word(wr_low_a),
        .direct(non_pwm),
        .reload(reload),
        .word(low_word),
        .active(active_a),
        .buffered(buf_a)
    );

    toc_compare_slot #(
        .WIDTH(16)
    ) i_toc_compare_slot_b (
        .pclk(pclk),
        .presetn(presetn),
        .write_word(wr_low_b),
        .direct(non_pwm),
        .reload(reload),
        .word(low_word),
        .active(active_b),
        .buffered(buf_b)
    );

    toc_compare_slot #(
        .WIDTH(16)
    ) i_toc_compare_slot_c (
        .pclk(pclk),
        .presetn(presetn),
        .write_word(wr_low_c),
        .direct(non_pwm),
        .reload(reload),
        .word(low_word),
        .active(active_c),
        .buffered(buf_c)
    );

    // Clears from service and write-one; a set in the same cycle wins
    always @*
    begin
        flag_clear = irq_ack;
        if (wr_flags)
            flag_clear = flag_clear | pwdata[2:0];
        next_match_flag = compare_match_flag & ~flag_clear;
        if (timer_tick)
            next_match_flag = next_match_flag | match_d;
    end

    function next_state;
        input cur;
        input [1:0] com;
        input pwm;
        input up;
        begin
            case (com)
                2'h0: next_state = cur;
                2'h1: next_state = pwm ? cur : ~cur;
                2'h2: next_state = pwm ? ~up : 1'b0;
                2'h3: next_state = pwm ? up : 1'b1;
                default: next_state = cur;
            endcase
        end
    endfunction

    // Counter and compare storage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_count <= `TOC_BOTTOM;
            count_up <= 1'b1;
            block_pending <= 1'b0;
            temp_high <= 8'h00;
        end
        else
        begin
            // Processor write outranks counting
            if (wr_count)
            begin
                timer_count <= pwdata[15:0];
                block_pending <= 1'b1;
            end
            else if (timer_tick)
            begin
                block_pending <= 1'b0;
                if (run)
                begin
                    if (dual_slope)
                    begin
                        if (count_up && timer_count == top_val && !block_pending)
                        begin
                            count_up <= 1'b0;
                            timer_count <= timer_count - 16'h0001;
                        end
                        else if (!count_up && timer_count == `TOC_BOTTOM && !block_pending)
                        begin
                            count_up <= 1'b1;
                            timer_count <= timer_count + 16'h0001;
                        end
                        else if (count_up)
                            timer_count <= timer_count + 16'h0001;
                        else
                            timer_count <= timer_count - 16'h0001;
                    end
                    else if (top_a && at_top && !block_pending)
                        timer_count <= `TOC_BOTTOM;
                    else
                        timer_count <= timer_count + 16'h0001;
                end
            end
            if (!dual_slope)
                count_up <= 1'b1;
            if (wr && paddr == `TOC_TEMP_OFS)
                temp_high <= pwdata[7:0];
        end
    end

    // Flags, output state, capture
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_d <= 3'h0;
            compare_match_flag <= 3'h0;
            compare_output_state <= 3'h0;
            capture_value <= 16'h0000;
            capture_flag <= 1'b0;
        end
        else
        begin
            // Match held until the next tick sets the flag
            if (timer_tick)
                match_d <= match;
            compare_match_flag <= next_match_flag;
            // Mode change alone never touches state
            compare_output_state <= {
                act[2] ? next_state(compare_output_state[2], com_c, !non_pwm, count_up)
                       : compare_output_state[2],
                act[1] ? next_state(compare_output_state[1], com_b, !non_pwm, count_up)
                       : compare_output_state[1],
                act[0] ? next_state(compare_output_state[0], com_a, !non_pwm, count_up)
                       : compare_output_state[0]};
            if (capture_event)
                capture_value <= timer_count;
            capture_flag <= capture_event ||
                (capture_flag && !(wr && paddr == `TOC_FLAGS_OFS && pwdata[3]));
        end
    end

    // Registered pins, irq and APB answer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `TOC_CTRL_RST;
            compare_irq_enable <= 3'h0;
            pin_out <= 3'h0;
            output_pin_direction <= 3'h0;
            compare_irq <= 3'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `TOC_CTRL_OFS)
                ctrl <= pwdata;
            if (wr && paddr == `TOC_IRQEN_OFS)
                compare_irq_enable <= pwdata[2:0];
            compare_irq <= compare_match_flag & compare_irq_enable;
            output_pin_direction <= ctrl[`TOC_CTRL_DIR_LSB +: 3];
            pin_out <= {
                (com_c != 2'h0) ? compare_output_state[2] : port_val[2],
                (com_b != 2'h0) ? compare_output_state[1] : port_val[1],
                (com_a != 2'h0) ? compare_output_state[0] : port_val[0]};
            // No wait state: ready rises in the first access cycle
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `TOC_CTRL_OFS: prdata <= ctrl;
                    `TOC_COUNT_OFS: prdata <= {16'h0000, timer_count};
                    `TOC_CMP_A_OFS: prdata <= {16'h0000, non_pwm ? active_a : buf_a};
                    `TOC_CMP_B_OFS: prdata <= {16'h0000, non_pwm ? active_b : buf_b};
                    `TOC_CMP_C_OFS: prdata <= {16'h0000, non_pwm ? active_c : buf_c};
                    `TOC_FLAGS_OFS: prdata <= {28'h0, capture_flag, compare_match_flag};
                    `TOC_IRQEN_OFS: prdata <= {29'h0, compare_irq_enable};
                    `TOC_CAPTURE_OFS: prdata <= {16'h0000, capture_value};
                    `TOC_STATE_OFS: prdata <= {29'h0, compare_output_state};
                    `TOC_TEMP_OFS: prdata <= {24'h0, temp_high};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            if (rd_acc && pready)
                prdata <= prdata;
        end
    end

endmodule // toc_timer16_output_compare

module toc_compare_slot #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Load controls
    input wire write_word,
    input wire direct,
    input wire reload,
    input wire [WIDTH-1:0] word,
    // Stored words
    output reg [WIDTH-1:0] active,
    output reg [WIDTH-1:0] buffered
);

    // Writes outrank a reload in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active <= `TOC_CMP_RST;
            buffered <= `TOC_CMP_RST;
        end
        else if (write_word)
        begin
            if (direct)
                active <= word;
            else
                buffered <= word;
        end
        else if (reload)
            active <= buffered;
    end

endmodule // toc_compare_slot

/* File: test/toc_checker.sv */
`timescale 1ns/1ps
module toc_checker (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Timer and pins
    input wire timer_tick,
    input wire capture_event,
    input wire [2:0] irq_ack,
    input wire [2:0] compare_irq,
    input wire [2:0] pin_out,
    input wire [2:0] output_pin_direction
);
    wire acc = psel && penable && pready;
    wire wr_ctrl = acc && pwrite && paddr == 12'h000;
    wire wr_ie = acc && pwrite && paddr == 12'h018;
    reg [31:0] ctrl;
    reg [1:0] age;
    // Shadow of CTRL; pins are only judged once it has settled
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctrl <= 32'h0;
            age <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            ctrl <= pwdata;
            age <= 2'h0;
        end
        else if (age != 2'h3)
            age <= age + 2'h1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && !penable |=> pready) else $error("no zero wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_pin_port: assert property (age > 2'h1 && ctrl[5:4] == 2'h0 |-> pin_out[0] == ctrl[16])
        else $error("pin not from port");
    a_dir_port: assert property (age > 2'h1 |-> output_pin_direction == ctrl[14:12])
        else $error("direction not from port");
    a_ctrl_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == ctrl)
        else $error("ctrl readback");
    a_unmapped_rd: assert property (acc && !pwrite && paddr > 12'h02c |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_slverr_low: assert property (pready |-> !pslverr) else $error("slave error raised");
    a_ack_clear: assert property (irq_ack != 3'h0 && !timer_tick
        |-> ##2 (compare_irq & $past(irq_ack, 2)) == 3'h0) else $error("ack kept irq");
    a_irq_tick: assert property ($rose(compare_irq[0]) && !$past(wr_ie, 2)
        |-> $past(timer_tick, 2)) else $error("irq without tick");
    c_irq: cover property ($rose(compare_irq[0]));
    c_ack: cover property (irq_ack[0] ##2 !compare_irq[0]);
    c_ctrl: cover property (wr_ctrl);
endmodule // toc_checker

bind toc_timer16_output_compare toc_checker i_toc_checker (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick, .capture_event,
    .irq_ack, .compare_irq, .pin_out, .output_pin_direction);

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "toc_defines.vh"
module tb;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    reg timer_tick = 1'b0;
    reg capture_event = 1'b0;
    reg [2:0] irq_ack = 3'h0;
    wire [31:0] prdata;
    wire pready;
    wire [2:0] compare_irq;
    wire [2:0] pin_out;
    wire [2:0] output_pin_direction;
    int n_fail = 0;
    int checks_done = 0;
    toc_timer16_output_compare i_toc_timer16_output_compare (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .timer_tick,
        .capture_event, .irq_ack, .compare_irq, .pin_out, .output_pin_direction);
    always #2.5 pclk = ~pclk;
    task finish_test;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            n_fail++;
            finish_test;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        reg [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task rc(input [11:0] a, input [31:0] e);
        reg [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    // One strobe cycle; also used for timer ticks spaced two cycles apart
    task strobe(input [2:0] ack, input cap, input tk);
        @(posedge pclk);
        irq_ack <= ack;
        capture_event <= cap;
        timer_tick <= tk;
        @(posedge pclk);
        irq_ack <= 3'h0;
        capture_event <= 1'b0;
        timer_tick <= 1'b0;
    endtask
    task s_cmp;
        for (int ch = 0; ch < 3; ch++)
        begin
            wr(`TOC_TEMP_OFS, 32'h12);
            wr(`TOC_CMP_LOW_OFS, 32'h34 + (ch << 8) + ch);
            rc(`TOC_CMP_A_OFS + 12'(4 * ch), 32'h1234 + ch);
        end
    endtask
    task s_match;
        wr(`TOC_CTRL_OFS, 32'h0000_0410);
        wr(`TOC_IRQEN_OFS, 32'h1);
        wr(`TOC_COUNT_OFS, 32'h1230);
        repeat (8) strobe(3'h0, 1'b0, 1'b1);
        rc(`TOC_FLAGS_OFS, 32'h7);
        chk({29'h0, compare_irq}, 32'h1);
        rc(`TOC_STATE_OFS, 32'h1);
        chk({29'h0, pin_out}, 32'h1);
        strobe(3'h1, 1'b0, 1'b0);
        rc(`TOC_FLAGS_OFS, 32'h6);
        wr(`TOC_FLAGS_OFS, 32'h6);
        rc(`TOC_FLAGS_OFS, 32'h0);
    endtask
    task s_block;
        wr(`TOC_COUNT_OFS, 32'h1234);
        repeat (2) strobe(3'h0, 1'b0, 1'b1);
        rc(`TOC_FLAGS_OFS, 32'h0);
        rc(`TOC_STATE_OFS, 32'h1);
    endtask
    task s_force;
        wr(`TOC_FORCE_OFS, 32'h1);
        rc(`TOC_STATE_OFS, 32'h0);
        wr(`TOC_FORCE_OFS, 32'h1);
        rc(`TOC_FLAGS_OFS, 32'h0);
        wr(`TOC_CTRL_OFS, 32'h0000_1400);
        wr(`TOC_FORCE_OFS, 32'h1);
        rc(`TOC_STATE_OFS, 32'h1);
        chk({29'h0, pin_out}, 32'h0);
        chk({29'h0, output_pin_direction}, 32'h1);
        wr(`TOC_CTRL_OFS, 32'h0000_041f);
        wr(`TOC_FORCE_OFS, 32'h1);
        rc(`TOC_STATE_OFS, 32'h1);
        chk({29'h0, pin_out}, 32'h1);
        wr(`TOC_TEMP_OFS, 32'h0);
        wr(`TOC_CMP_LOW_OFS, 32'h155);
        rc(`TOC_CMP_B_OFS, 32'h55);
    endtask
    task s_top;
        wr(`TOC_COUNT_OFS, 32'h1233);
        repeat (2) strobe(3'h0, 1'b0, 1'b1);
        rc(`TOC_COUNT_OFS, 32'h0);
        rc(`TOC_FLAGS_OFS, 32'h2);
        wr(`TOC_CTRL_OFS, 32'h0);
        rc(`TOC_CMP_B_OFS, 32'h55);
        rc(`TOC_CMP_A_OFS, 32'h0);
        wr(`TOC_FLAGS_OFS, 32'h7);
    endtask
    task s_cap;
        wr(`TOC_CTRL_OFS, 32'h0000_0150);
        wr(`TOC_COUNT_OFS, 32'h0abc);
        strobe(3'h0, 1'b1, 1'b0);
        wr(`TOC_COUNT_OFS, 32'h0def);
        strobe(3'h0, 1'b1, 1'b0);
        rc(`TOC_CAPTURE_OFS, 32'h0def);
        rc(`TOC_FLAGS_OFS, 32'h8);
        wr(`TOC_FLAGS_OFS, 32'h8);
        rc(`TOC_FLAGS_OFS, 32'h0);
        rc(12'h030, 32'h0);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rc(`TOC_STATE_OFS, 32'h0);
        s_cmp;
        s_match;
        s_block;
        s_force;
        s_top;
        s_cap;
        finish_test;
    end
endmodule // tb
